// ---- verilog/ocf_cfg.svh ----
// Constants of the oscillator configuration loader: word layouts, offsets, OTP map, timing.
// Assumes inclusion by ocf_pkg and the design modules only.
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH
`define OCF_ADDR_OSC        12'h000
`define OCF_ADDR_SIGN       12'h004
`define OCF_ADDR_DBG        12'h008
`define OCF_ADDR_LOCK       12'h00C
`define OCF_ADDR_UNLOCK     12'h010
`define OCF_ADDR_STATUS     12'h014
`define OCF_ADDR_OTP_BASE   12'h400
`define OCF_ADDR_OTP_LAST   12'h7FC
`define OCF_OSC_UNIMP       24'hFFFF00
`define OCF_SIGN_UNIMP      24'hFF7FFF
`define OCF_WORD_MASK       24'hFFFFFF
`define OCF_OTP_PROG_BASE   24'h801700
`define OCF_OTP_PROG_LAST   24'h8017FE
`define OCF_OTP_BYTES       256
`define OCF_OTP_WORDS       128
`define OCF_DBG_RAM_BYTES   80
`define OCF_UNLOCK_KEY1     8'h55
`define OCF_UNLOCK_KEY2     8'hAA
`define OCF_FIELD_CKSM      7:6
`define OCF_BIT_ONEWAY      5
`define OCF_BIT_PLL_SOURCE_SEL       4
`define OCF_BIT_SOSC        3
`define OCF_BIT_CLKOEN      2
`define OCF_FIELD_POSC      1:0
`define OCF_BIT_SIGN_RSVD   15
`define OCF_LOAD_CYCLES     4
`endif

// ---- verilog/ocf_pkg.sv ----
// Types of the oscillator configuration loader.
// Assumes ocf_cfg.svh for numeric constants.
`include "ocf_cfg.svh"
package ocf_pkg;
   typedef enum logic [1:0] {POSC_EXT = 2'b00, POSC_XT = 2'b01, POSC_HS = 2'b10, POSC_OFF = 2'b11} ocf_posc_e;
   typedef enum {LD_IDLE, LD_OSC, LD_SIGN, LD_DONE} ocf_ld_e;
   typedef struct packed {
      logic       clk_switch_en;
      logic       fail_safe_en;
      logic       pll_from_primary;
      logic       sosc_crystal;
      logic       clkout_on_pin;
      logic       ext_clk_accept;
      ocf_posc_e  posc_mode;
   } ocf_dec_s;
   typedef struct packed {
      logic [23:0] osc_word;
      logic [23:0] sign_word;
      logic [1:0]  dbg_pair;
      logic        dbg_en;
   } ocf_nv_s;
endpackage : ocf_pkg

// ---- verilog/ocf_clkout.sv ----
// Quarter-phase generator: instruction cycle and clock-out from the oscillator time base.
// Assumes the time base arrives as a single-cycle tick on CLK's domain.
`timescale 1ns/1ps
module ocf_clkout (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Time base
   input  wire logic osc_tick,
   // Outputs
   output logic      clkout,
   output logic      cycle_start
);
   import ocf_pkg::*;
   typedef struct packed {
      logic [1:0] q;
      logic       co;
      logic       cs;
   } ocf_qs_s;
   ocf_qs_s s_q, s_d;
   always_comb begin
      s_d    = s_q;
      s_d.cs = 1'b0;
      if (osc_tick) begin
         // Two ticks per half cycle makes TCY four times the time base
         s_d.q  = s_q.q + 2'd1;
         s_d.co = (s_d.q >= 2'd2);
         s_d.cs = (s_d.q == 2'd0);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign clkout      = s_q.co;
   assign cycle_start = s_q.cs;
   chk_clkout_phase: assert property (@(posedge clk) disable iff (rst) s_q.co == (s_q.q >= 2'd2))
      else $error("clock-out phase wrong");
endmodule : ocf_clkout

// ---- verilog/ocf_top.sv ----
// Oscillator configuration loader: samples configuration words, decodes them, APB view, OTP guard.
// Assumes a non-volatile word source, APB master on CLK, async pins resynchronised here.
`timescale 1ns/1ps
`include "ocf_cfg.svh"
module ocf_top #(
   parameter int OTP_WORDS = `OCF_OTP_WORDS
) (
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RESET,
   // APB
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   output logic [31:0]            PRDATA,
   // Non-volatile configuration source
   input  wire ocf_pkg::ocf_nv_s  NV_WORDS,
   // Programmer side (external, asynchronous)
   input  wire logic              PROG_MODE,
   input  wire logic              PROG_WR,
   input  wire logic              CHIP_ERASE,
   input  wire logic [6:0]        PROG_OTP_ADDR,
   input  wire logic [31:0]       PROG_OTP_DATA,
   // Oscillator time base
   input  wire logic              OSC_TICK,
   // Decoded outputs
   output ocf_pkg::ocf_dec_s      DECODE,
   output logic                   PIN_LOCK,
   output logic                   CLOCK_OUT,
   output logic                   DBG_RAM_RESERVE,
   output logic [7:0]             DBG_RAM_BYTES,
   output logic [1:0]             DBG_PAIR_SEL,
   output logic                   CFG_READY
);
   import ocf_pkg::*;

   typedef struct packed {
      ocf_ld_e     ld;
      logic [23:0] osc;
      logic [23:0] sign;
      logic [1:0]  dpair;
      logic        den;
      ocf_dec_s    dec;
      logic        lock;
      logic        locked_once;
      logic        key1;
      logic        keyh;
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
      logic        otp_err;
      logic [2:0]  pm_s;
      logic [2:0]  pw_s;
      logic [6:0]  pa1;
      logic [6:0]  pa2;
      logic [31:0] pd1;
      logic [31:0] pd2;
      logic [7:0]  dbytes;
      logic        cfg_rdy;
      logic [2:0]  ce_s;
      logic        clkout;
   } ocf_st_s;

   ocf_st_s     s_q, s_d;
   logic [31:0] otp_mem [OTP_WORDS];
   logic [OTP_WORDS-1:0] otp_used_q;
   logic        co_raw;
   logic        otp_we;

   function automatic ocf_dec_s decode_osc(input logic [23:0] w);
      ocf_dec_s d;
      d.clk_switch_en    = ~w[7];
      d.fail_safe_en     = (w[`OCF_FIELD_CKSM] == 2'b00);
      d.pll_from_primary = w[`OCF_BIT_PLL_SOURCE_SEL];
      d.sosc_crystal     = w[`OCF_BIT_SOSC];
      d.posc_mode        = ocf_posc_e'(w[`OCF_FIELD_POSC]);
      d.ext_clk_accept   = (d.posc_mode == POSC_EXT);
      d.clkout_on_pin    = w[`OCF_BIT_CLKOEN] &&
                           (d.posc_mode == POSC_EXT || d.posc_mode == POSC_OFF);
      return d;
   endfunction : decode_osc

   function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction : apb_hit

   ocf_clkout u_clkout (
      .clk         (CLK),
      .rst         (RESET),
      .osc_tick    (OSC_TICK),
      .clkout      (co_raw),
      .cycle_start ()
   );

   always_comb begin
      logic acc;
      logic wr;
      logic [11:0] oa;
      acc = 1'b0;
      wr  = 1'b0;
      oa  = '0;
      s_d = s_q;
      s_d.pm_s = {s_q.pm_s[1:0], PROG_MODE};
      s_d.pw_s = {s_q.pw_s[1:0], PROG_WR};
      // Programmer address and data pass two stages; the strobes they go with pass three
      s_d.pa1 = PROG_OTP_ADDR;
      s_d.pa2 = s_q.pa1;
      s_d.pd1 = PROG_OTP_DATA;
      s_d.pd2 = s_q.pd1;
      s_d.ce_s = {s_q.ce_s[1:0], CHIP_ERASE};
      s_d.ready  = 1'b0;
      s_d.slverr = 1'b0;
      s_d.clkout = co_raw & s_q.dec.clkout_on_pin;
      case (s_q.ld)
         LD_IDLE: s_d.ld = LD_OSC;
         LD_OSC: begin
            s_d.osc = NV_WORDS.osc_word | `OCF_OSC_UNIMP;
            s_d.dec = decode_osc(NV_WORDS.osc_word);
            s_d.ld  = LD_SIGN;
         end
         LD_SIGN: begin
            s_d.sign  = NV_WORDS.sign_word | `OCF_SIGN_UNIMP;
            s_d.dpair = NV_WORDS.dbg_pair;
            s_d.den   = NV_WORDS.dbg_en;
            s_d.dbytes = NV_WORDS.dbg_en ? 8'(`OCF_DBG_RAM_BYTES) : 8'h00;
            s_d.cfg_rdy = 1'b1;
            s_d.ld    = LD_DONE;
         end
         LD_DONE: s_d.ld = LD_DONE;
         default: s_d.ld = LD_IDLE;
      endcase
      // One-cycle access phase answer
      acc = PSEL && PENABLE && !s_q.ready;
      wr  = acc && PWRITE;
      if (acc) begin
         s_d.ready = 1'b1;
         s_d.rdata = '0;
         oa = PADDR - `OCF_ADDR_OTP_BASE;
         if (apb_hit(PADDR, `OCF_ADDR_OSC)) begin
            s_d.rdata = {8'h00, s_q.osc};
         end else if (apb_hit(PADDR, `OCF_ADDR_SIGN)) begin
            s_d.rdata = {8'h00, s_q.sign};
         end else if (apb_hit(PADDR, `OCF_ADDR_DBG)) begin
            s_d.rdata = {29'h0, s_q.den, s_q.dpair};
         end else if (apb_hit(PADDR, `OCF_ADDR_LOCK)) begin
            s_d.rdata = {30'h0, s_q.locked_once, s_q.lock};
            if (wr) begin
               // Lock changes only right after the unlock key pair
               if (s_q.key1 && !(s_q.osc[`OCF_BIT_ONEWAY] && s_q.locked_once)) begin
                  s_d.lock = PWDATA[0];
                  if (PWDATA[0]) begin
                     s_d.locked_once = 1'b1;
                  end
               end
               s_d.key1 = 1'b0;
               s_d.keyh = 1'b0;
            end
         end else if (apb_hit(PADDR, `OCF_ADDR_UNLOCK)) begin
            if (wr) begin
               // Second key arms the lock only straight after the first
               s_d.key1 = s_q.keyh && (PWDATA[7:0] == `OCF_UNLOCK_KEY2);
               s_d.keyh = (PWDATA[7:0] == `OCF_UNLOCK_KEY1);
            end
         end else if (apb_hit(PADDR, `OCF_ADDR_STATUS)) begin
            s_d.rdata = {29'h0, s_q.otp_err, s_q.pm_s[2], s_q.ld == LD_DONE};
            if (wr && PWDATA[2]) begin
               s_d.otp_err = 1'b0;
            end
         end else if (PADDR >= `OCF_ADDR_OTP_BASE && PADDR <= `OCF_ADDR_OTP_LAST) begin
            s_d.rdata = otp_mem[oa[8:2]];
            if (wr) begin
               s_d.slverr = 1'b1;
            end
         end else begin
            s_d.slverr = 1'b1;
         end
      end
      // Hardware-set OTP error wins over software clear
      if (otp_we && otp_used_q[s_q.pa2]) begin
         s_d.otp_err = 1'b1;
      end
   end

   // Programmer strobe: rising edge of the synchronised write, only in programming mode
   assign otp_we = s_q.pm_s[2] && s_q.pw_s[2] && !s_q.pw_s[1] ? 1'b0 :
                   (s_q.pm_s[2] && s_q.pw_s[1] && !s_q.pw_s[2]);

   always_ff @(posedge CLK) begin
      // OTP writable only by programmer; chip erase has no path here
      if (otp_we && !otp_used_q[s_q.pa2]) begin
         otp_mem[s_q.pa2] <= s_q.pd2;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         otp_used_q <= '0;
      end else if (otp_we) begin
         otp_used_q[s_q.pa2] <= 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign PREADY          = s_q.ready;
   assign PSLVERR         = s_q.slverr;
   assign PRDATA          = s_q.rdata;
   assign DECODE          = s_q.dec;
   assign PIN_LOCK        = s_q.lock;
   assign CLOCK_OUT       = s_q.clkout;
   assign DBG_RAM_RESERVE = s_q.den;
   assign DBG_RAM_BYTES   = s_q.dbytes;
   assign DBG_PAIR_SEL    = s_q.dpair;
   assign CFG_READY       = s_q.cfg_rdy;

   chk_cksm_decode: assert property (@(posedge CLK) disable iff (RESET)
      CFG_READY |-> (DECODE.fail_safe_en == (s_q.osc[7:6] == 2'b00)) && (DECODE.clk_switch_en == !s_q.osc[7]))
      else $error("clock switch decode wrong");
   chk_lock_oneway: assert property (@(posedge CLK) disable iff (RESET)
      (s_q.osc[`OCF_BIT_ONEWAY] && s_q.locked_once && s_q.lock) |=> s_q.lock)
      else $error("one-way lock cleared");
   chk_pll_source: assert property (@(posedge CLK) disable iff (RESET)
      CFG_READY |-> DECODE.pll_from_primary == s_q.osc[`OCF_BIT_PLL_SOURCE_SEL])
      else $error("pll source wrong");
   chk_sosc_mode: assert property (@(posedge CLK) disable iff (RESET)
      CFG_READY |-> DECODE.sosc_crystal == s_q.osc[`OCF_BIT_SOSC])
      else $error("secondary osc wrong");
   chk_clkout_gate: assert property (@(posedge CLK) disable iff (RESET)
      !DECODE.clkout_on_pin |=> !CLOCK_OUT)
      else $error("clock-out leaked");
   chk_posc_decode: assert property (@(posedge CLK) disable iff (RESET)
      CFG_READY |-> DECODE.posc_mode == ocf_posc_e'(s_q.osc[1:0]))
      else $error("primary mode wrong");
   chk_unimp_ones: assert property (@(posedge CLK) disable iff (RESET)
      CFG_READY |-> (s_q.osc[23:8] == 16'hFFFF) && (s_q.sign[14:0] == 15'h7FFF))
      else $error("unimplemented bits not one");
   chk_otp_nowrite: assert property (@(posedge CLK) disable iff (RESET)
      (PSEL && PENABLE && PWRITE && !PREADY && PADDR >= `OCF_ADDR_OTP_BASE && PADDR <= `OCF_ADDR_OTP_LAST)
      |=> PSLVERR)
      else $error("otp write not refused");
   chk_ext_accept: assert property (@(posedge CLK) disable iff (RESET)
      DECODE.ext_clk_accept |-> DECODE.posc_mode == POSC_EXT)
      else $error("external clock accepted wrongly");
   chk_cfg_hold: assert property (@(posedge CLK) disable iff (RESET)
      CFG_READY |=> $stable(s_q.osc) && $stable(s_q.sign))
      else $error("configuration changed after load");
endmodule : ocf_top

// ---- tb/ocf_prog_model.sv ----
// Behavioural device programmer: holds the stored words and burns the OTP.
// Assumes the bench calls its tasks from one process on the design clock.
`timescale 1ns/1ps
module ocf_prog_model (
   // Clock
   input  wire logic        clk,
   // Programmer lines
   output logic             prog_mode,
   output logic             prog_wr,
   output logic             chip_erase,
   output logic [6:0]       otp_addr,
   output logic [31:0]      otp_data,
   // Stored words
   output ocf_pkg::ocf_nv_s nv
);
   import ocf_pkg::*;
   logic [127:0] burnt;
   initial begin
      {prog_mode, prog_wr, chip_erase, burnt} = '0;
      otp_addr = 7'h00;
      otp_data = 32'h0;
      nv = '0;
   end
   task automatic set_words(input logic [23:0] o, input logic [23:0] s, input logic [2:0] d);
      nv.osc_word <= (o[1:0] == 2'b10) ? (o & 24'hFFFFEF) : o;
      nv.sign_word <= s & 24'hFF7FFF;
      {nv.dbg_en, nv.dbg_pair} <= d;
   endtask : set_words
   // A repeat burn only happens when the bench asks for it
   task automatic burn(input logic [6:0] a, input logic [31:0] d, input logic again);
      if (burnt[a] && !again) return;
      burnt[a] = 1'b1;
      @(posedge clk);
      prog_mode <= 1'b1;
      otp_addr <= a;
      otp_data <= d;
      repeat (3) @(posedge clk);
      prog_wr <= 1'b1;
      repeat (6) @(posedge clk);
      prog_wr <= 1'b0;
      repeat (3) @(posedge clk);
      prog_mode <= 1'b0;
      // Released address and data lines show the complement of the last address and word
      otp_data <= ~d;
      otp_addr <= ~a;
   endtask : burn
   task automatic erase();
      @(posedge clk);
      chip_erase <= 1'b1;
      repeat (6) @(posedge clk);
      chip_erase <= 1'b0;
   endtask : erase
endmodule : ocf_prog_model

// ---- tb/test_oscillator_config_fuses.sv ----
// Self-checking bench of the configuration loader: decode, APB view, lock, clock-out, OTP.
// Assumes ocf_prog_model as the programmer and APB driven from this module.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_oscillator_config_fuses;
   import ocf_pkg::*;
   logic        clk, rst, psel, penable, pwrite, osc_tick, err;
   logic        pready, pslverr, pin_lock, clock_out, dbg_res, cfg_ready;
   logic        prog_mode, prog_wr, chip_erase;
   logic [11:0] paddr, a12;
   logic [31:0] pwdata, prdata, rd, w, otp_data;
   logic [23:0] osc;
   logic [7:0]  dbg_bytes;
   logic [6:0]  otp_addr, a7;
   logic [1:0]  dbg_pair;
   ocf_dec_s    decode;
   ocf_nv_s     nv;
   int          mismatches, total_checks, cyc, n;
   ocf_top dut (
      .CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
      .NV_WORDS(nv), .PROG_MODE(prog_mode), .PROG_WR(prog_wr), .CHIP_ERASE(chip_erase),
      .PROG_OTP_ADDR(otp_addr), .PROG_OTP_DATA(otp_data), .OSC_TICK(osc_tick),
      .DECODE(decode), .PIN_LOCK(pin_lock), .CLOCK_OUT(clock_out), .DBG_RAM_RESERVE(dbg_res),
      .DBG_RAM_BYTES(dbg_bytes), .DBG_PAIR_SEL(dbg_pair), .CFG_READY(cfg_ready));
   ocf_prog_model prog (
      .clk(clk), .prog_mode(prog_mode), .prog_wr(prog_wr), .chip_erase(chip_erase),
      .otp_addr(otp_addr), .otp_data(otp_data), .nv(nv));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic tally_and_finish();
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic lock_wr(input logic v);
      apb(1'b1, 12'h010, 32'h55);
      apb(1'b1, 12'h010, 32'hAA);
      apb(1'b1, 12'h00C, {31'h0, v});
      @(posedge clk);
   endtask : lock_wr
   function automatic ocf_dec_s exp_dec(input logic [7:0] o);
      exp_dec.clk_switch_en = !o[7];
      exp_dec.fail_safe_en = (o[7:6] == 2'b00);
      exp_dec.pll_from_primary = o[4];
      exp_dec.sosc_crystal = o[3];
      exp_dec.clkout_on_pin = o[2] && (o[1:0] == 2'b00 || o[1:0] == 2'b11);
      exp_dec.ext_clk_accept = (o[1:0] == 2'b00);
      exp_dec.posc_mode = ocf_posc_e'(o[1:0]);
   endfunction : exp_dec
   initial begin
      {rst, psel, penable, pwrite, osc_tick} = 5'h10;
      paddr = 12'h000;
      pwdata = 32'h0;
      void'($urandom(32'hB8D3));
      repeat (10) @(posedge clk);
      // Each pass walks one code of both two-bit fields and one debug setting
      for (int i = 0; i < 8; i++) begin
         osc = $urandom();
         osc[7:6] = i[1:0];
         osc[1:0] = i[2:1];
         rst <= 1'b1;
         prog.set_words(osc, $urandom(), 3'(i));
         repeat (3) @(posedge clk);
         rst <= 1'b0;
         for (int k = 0; k < 20 && cfg_ready !== 1'b1; k++) @(posedge clk);
         osc = nv.osc_word;
         `CHK(cfg_ready, 1'b1)
         `CHK(decode, exp_dec(osc[7:0]))
         `CHK(dbg_res, nv.dbg_en)
         `CHK(dbg_bytes, nv.dbg_en ? 8'h50 : 8'h00)
         `CHK(dbg_pair, nv.dbg_pair)
         apb(1'b0, 12'h000, 32'h0);
         `CHK(rd[23:0], {16'hFFFF, osc[7:0]})
         apb(1'b0, 12'h004, 32'h0);
         `CHK(rd[23:0], 24'hFF7FFF)
         // Stored words move after the load; the decode must stay put
         prog.set_words(~osc, 24'h0, 3'h0);
         apb(1'b1, 12'h00C, 32'h1);
         @(posedge clk);
         `CHK(pin_lock, 1'b0)
         apb(1'b1, 12'h010, 32'h55);
         apb(1'b1, 12'h00C, 32'h1);
         @(posedge clk);
         `CHK(pin_lock, 1'b0)
         lock_wr(1'b1);
         `CHK(pin_lock, 1'b1)
         lock_wr(1'b0);
         `CHK(pin_lock, osc[5])
         `CHK(decode, exp_dec(osc[7:0]))
         osc_tick <= 1'b1;
         repeat (8) @(posedge clk);
         n = 0;
         repeat (40) begin
            @(posedge clk);
            n += (clock_out === 1'b1);
         end
         osc_tick <= 1'b0;
         `CHK(n, exp_dec(osc[7:0]).clkout_on_pin ? 40'd20 : 40'd0)
      end
      // Last pass hits the top OTP word
      for (int i = 0; i < 4; i++) begin
         a7 = 7'(i * 42 + 1);
         a12 = 12'h400 + {a7, 2'b00};
         w = $urandom();
         prog.burn(a7, w, 1'b0);
         repeat (8) @(posedge clk);
         apb(1'b1, a12, ~w);
         `CHK(err, 1'b1)
         prog.erase();
         prog.burn(a7, ~w, 1'b1);
         repeat (8) @(posedge clk);
         apb(1'b0, a12, 32'h0);
         `CHK(rd, w)
         apb(1'b0, 12'h014, 32'h0);
         `CHK(rd[2], 1'b1)
         apb(1'b1, 12'h014, 32'h4);
         apb(1'b0, 12'h014, 32'h0);
         `CHK(rd[2:0], 3'b001)
      end
      apb(1'b0, 12'h020, 32'h0);
      `CHK(err, 1'b1)
      tally_and_finish();
   end
endmodule : test_oscillator_config_fuses
